// [rtl/octal_uart_cfg_pkg.sv]
package octal_uart_cfg_pkg;

    // global register offsets
    localparam logic [7:0] OFS_IRQ_SUMMARY  = 8'h80;
    localparam logic [7:0] OFS_IRQ_CODE_LO  = 8'h81;
    localparam logic [7:0] OFS_IRQ_CODE_MID = 8'h82;
    localparam logic [7:0] OFS_IRQ_CODE_HI  = 8'h83;
    localparam logic [7:0] OFS_TIMER_CTRL   = 8'h84;
    localparam logic [7:0] OFS_TIMER_ZERO   = 8'h85;
    localparam logic [7:0] OFS_TIMER_LOW    = 8'h86;
    localparam logic [7:0] OFS_TIMER_HIGH   = 8'h87;
    localparam logic [7:0] OFS_SAMPLE_X8    = 8'h88;
    localparam logic [7:0] OFS_SAMPLE_X4    = 8'h89;
    localparam logic [7:0] OFS_SOFT_RESET   = 8'h8A;
    localparam logic [7:0] OFS_SLEEP_EN     = 8'h8B;
    localparam logic [7:0] OFS_REVISION     = 8'h8C;
    localparam logic [7:0] OFS_IDENTIFIER   = 8'h8D;
    localparam logic [7:0] OFS_BROADCAST    = 8'h8E;

    // channel register offsets inside each sixteen-byte window
    localparam logic [3:0] CH_OFS_TX_HOLD   = 4'h0;
    localparam logic [3:0] CH_OFS_IRQ_STAT  = 4'h2;

    // field positions, masks and reset values
    localparam int         BCAST_BIT        = 0;
    localparam int         GLOBAL_SEL_BIT   = 7;
    localparam logic [7:0] TIMER_CTRL_MASK  = 8'h0F;
    localparam logic [7:0] SLEEP_ALL        = 8'hFF;
    localparam logic [7:0] REG_RESET        = 8'h00;

    typedef enum logic [1:0] {
        SAMPLE_16X = 2'b00,
        SAMPLE_8X  = 2'b01,
        SAMPLE_4X  = 2'b10
    } sample_mode_t;

    typedef enum logic [0:0] {
        ST_AWAKE  = 1'b0,
        ST_ASLEEP = 1'b1
    } sleep_state_t;

    // access forwarded to the channel register files
    typedef struct packed {
        logic [7:0] sel;
        logic [3:0] ofs;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } chan_bus_t;

endpackage : octal_uart_cfg_pkg

// [rtl/octal_uart_cfg.sv]
`timescale 1ns/100ps
module octal_uart_cfg
    import octal_uart_cfg_pkg::*;
#(
    parameter logic [7:0] DEV_REVISION   = 8'h01,   // arbitrary value
    parameter logic [7:0] DEV_IDENTIFIER = 8'h5A,   // arbitrary value
    parameter int         CHANNELS       = 8
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // host parallel bus
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // channel register files
    input  wire logic [63:0] chan_rdata_i,
    output chan_bus_t        chan_bus_o,
    output logic      [7:0]  soft_reset_o,
    output logic      [15:0] sample_mode_o,
    // channel status
    input  wire logic [7:0]  chan_irq_pending_i,
    input  wire logic [23:0] chan_irq_code_i,
    input  wire logic [7:0]  rx_irq_en_i,
    input  wire logic [7:0]  tx_irq_en_i,
    input  wire logic [7:0]  modem_irq_en_i,
    input  wire logic [7:0]  modem_delta_i,
    // serial pins seen for wake-up
    input  wire logic [7:0]  rx_i,
    input  wire logic [31:0] modem_i,
    // device outputs
    output logic             irq_o,
    output logic             osc_en_o,
    output logic             oscillator_output_pin,
    output logic      [3:0]  timer_ctrl_o,
    output logic      [15:0] timer_reload_o
);

    // the address map has room for exactly eight channel windows
    if (CHANNELS != 8) begin : g_bad_channels
        $error("octal_uart_cfg serves exactly eight channels");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // both bits set picks 4X so a half-written pair never lands on 8X
    function automatic sample_mode_t pick_mode(input logic x8, input logic x4);
        if (x4) begin
            return SAMPLE_4X;
        end else if (x8) begin
            return SAMPLE_8X;
        end
        return SAMPLE_16X;
    endfunction : pick_mode

    // true when the address falls into the channel windows
    function automatic logic is_chan(input logic [7:0] a);
        return !a[GLOBAL_SEL_BIT];
    endfunction : is_chan

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic         host_wr_global;
    logic         host_wr_chan;
    logic         host_rd_chan;
    logic [2:0]   chan_idx;
    logic [7:0]   chan_onehot;

    assign chan_idx       = addr_i[6:4];
    assign chan_onehot    = 8'h01 << chan_idx;
    assign host_wr_global = wr_i && !is_chan(addr_i);
    assign host_wr_chan   = wr_i && is_chan(addr_i);
    assign host_rd_chan   = rd_i && is_chan(addr_i);

    ////////////////////////////////////////////////////////////////////////////
    // global read/write registers

    logic [7:0] timer_ctrl;
    logic [7:0] timer_low;
    logic [7:0] timer_high;
    logic [7:0] sample_x8_select;
    logic [7:0] sample_x4_select;
    logic [7:0] sleep_enable;
    logic [7:0] broadcast_write_control;

    // software-written controls
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timer_ctrl              <= REG_RESET;
            timer_low               <= REG_RESET;
            timer_high              <= REG_RESET;
            sample_x8_select        <= REG_RESET;
            sample_x4_select        <= REG_RESET;
            sleep_enable            <= REG_RESET;
            broadcast_write_control <= REG_RESET;
        end else if (host_wr_global) begin
            case (addr_i)
                OFS_TIMER_CTRL: timer_ctrl       <= wdata_i & TIMER_CTRL_MASK;
                OFS_TIMER_LOW:  timer_low        <= wdata_i;
                OFS_TIMER_HIGH: timer_high       <= wdata_i;
                OFS_SAMPLE_X8:  sample_x8_select <= wdata_i;
                OFS_SAMPLE_X4:  sample_x4_select <= wdata_i;
                OFS_SLEEP_EN:   sleep_enable     <= wdata_i;
                OFS_BROADCAST:  broadcast_write_control <= {7'h00, wdata_i[BCAST_BIT]};
                default: ;
            endcase
        end
    end

    // register outputs that steer the channels
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_mode_o  <= {8{SAMPLE_16X}};
            timer_ctrl_o   <= 4'h0;
            timer_reload_o <= 16'h0000;
        end else begin
            for (int c = 0; c < 8; c++) begin
                sample_mode_o[2*c +: 2] <= pick_mode(sample_x8_select[c],
                                                     sample_x4_select[c]);
            end
            timer_ctrl_o   <= timer_ctrl[3:0];
            timer_reload_o <= {timer_high, timer_low};
        end
    end

    // soft reset is a pulse: nothing is stored, so it cannot be read back
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            soft_reset_o <= 8'h00;
        end else if (host_wr_global && addr_i == OFS_SOFT_RESET) begin
            soft_reset_o <= wdata_i;
        end else begin
            soft_reset_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel access forwarding

    // reads never broadcast; only writes fan out to every channel
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chan_bus_o <= '0;
        end else begin
            chan_bus_o.ofs   <= addr_i[3:0];
            chan_bus_o.wdata <= wdata_i;
            chan_bus_o.wr    <= host_wr_chan;
            chan_bus_o.rd    <= host_rd_chan;
            if (host_wr_chan && broadcast_write_control[BCAST_BIT]) begin
                chan_bus_o.sel <= 8'hFF;
            end else if (host_wr_chan || host_rd_chan) begin
                chan_bus_o.sel <= chan_onehot;
            end else begin
                chan_bus_o.sel <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-up event detection

    logic [7:0]  rx_prev;
    logic [31:0] modem_prev;
    logic [7:0]  rx_fall;
    logic [7:0]  tx_load;
    logic [7:0]  modem_change;
    logic [7:0]  chan_event;
    logic [7:0]  wake_silent;
    logic        any_event;

    // previous pin levels for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_prev    <= 8'hFF;
            modem_prev <= 32'h0000_0000;
        end else begin
            rx_prev    <= rx_i;
            modem_prev <= modem_i;
        end
    end

    // per-channel events; a broadcast write to the transmit holding offset loads every transmitter
    always_comb begin
        rx_fall = rx_prev & ~rx_i;
        tx_load = 8'h00;
        if (host_wr_chan && addr_i[3:0] == CH_OFS_TX_HOLD) begin
            tx_load = broadcast_write_control[BCAST_BIT] ? 8'hFF : chan_onehot;
        end
        for (int c = 0; c < 8; c++) begin
            modem_change[c] = |(modem_prev[4*c +: 4] ^ modem_i[4*c +: 4]);
        end
        chan_event  = rx_fall | tx_load | modem_change;
        any_event   = |chan_event;
        wake_silent = (rx_fall & ~rx_irq_en_i) | (tx_load & ~tx_irq_en_i)
                    | (modem_change & ~modem_irq_en_i);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep state machine

    sleep_state_t state;
    sleep_state_t next_state;
    logic [7:0]   wake_flag;
    logic [7:0]   wake_set;
    logic [7:0]   wake_clr;
    logic [7:0]   summary;
    logic         entry_ok;

    assign summary  = chan_irq_pending_i | wake_flag;
    assign entry_ok = summary == 8'h00 && sleep_enable == SLEEP_ALL
                   && modem_delta_i == 8'h00 && &rx_i && !any_event;

    // leaving on a zero write too lets software cancel sleep at once
    always_comb begin
        next_state = state;
        case (state)
            ST_AWAKE: begin
                if (entry_ok) begin
                    next_state = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                if (any_event || sleep_enable != SLEEP_ALL) begin
                    next_state = ST_AWAKE;
                end
            end
            default: next_state = ST_AWAKE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // silent wake flag: only events that end a sleep set it
    assign wake_set = (state == ST_ASLEEP) ? (chan_event & wake_silent) : 8'h00;
    assign wake_clr = (host_rd_chan && addr_i[3:0] == CH_OFS_IRQ_STAT
                       && !chan_irq_pending_i[chan_idx]) ? chan_onehot : 8'h00;

    // set wins over clear so a wake in the reading cycle is kept
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_flag <= 8'h00;
        end else begin
            wake_flag <= (wake_flag & ~wake_clr) | wake_set;
        end
    end

    // oscillator: a divided toggle stands in for the crystal swing
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_en_o              <= 1'b1;
            oscillator_output_pin <= 1'b0;
        end else begin
            osc_en_o <= (next_state == ST_AWAKE);
            if (state == ST_AWAKE) begin
                oscillator_output_pin <= ~oscillator_output_pin;
            end else begin
                oscillator_output_pin <= 1'b0;
            end
        end
    end

    // one interrupt line for every channel and for silent wake-ups
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |summary;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0]  next_rdata;
    logic [23:0] code_packed;

    // a silently woken channel shows its summary bit with code zero
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            code_packed[3*c +: 3] = chan_irq_pending_i[c] ? chan_irq_code_i[3*c +: 3]
                                                          : 3'b000;
        end
        next_rdata = 8'h00;
        if (is_chan(addr_i)) begin
            next_rdata = chan_rdata_i[8*chan_idx +: 8];
        end else begin
            case (addr_i)
                OFS_IRQ_SUMMARY:  next_rdata = summary;
                OFS_IRQ_CODE_LO:  next_rdata = code_packed[7:0];
                OFS_IRQ_CODE_MID: next_rdata = code_packed[15:8];
                OFS_IRQ_CODE_HI:  next_rdata = code_packed[23:16];
                OFS_TIMER_CTRL:   next_rdata = timer_ctrl;
                OFS_TIMER_ZERO:   next_rdata = 8'h00;
                OFS_TIMER_LOW:    next_rdata = timer_low;
                OFS_TIMER_HIGH:   next_rdata = timer_high;
                OFS_SAMPLE_X8:    next_rdata = sample_x8_select;
                OFS_SAMPLE_X4:    next_rdata = sample_x4_select;
                OFS_SLEEP_EN:     next_rdata = sleep_enable;
                OFS_REVISION:     next_rdata = DEV_REVISION;
                OFS_IDENTIFIER:   next_rdata = DEV_IDENTIFIER;
                OFS_BROADCAST:    next_rdata = broadcast_write_control;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_sleep_entry: assert property (
        $rose(state == ST_ASLEEP) |-> $past(summary) == 8'h00
            && $past(sleep_enable) == SLEEP_ALL && $past(&rx_i))
        else $error("sleep entered while a condition was unmet");

    a_osc_halted: assert property (
        (state == ST_ASLEEP) [*2] |-> !oscillator_output_pin && !osc_en_o)
        else $error("oscillator running during sleep");

    a_wake_rx: assert property (
        (state == ST_ASLEEP) && |rx_fall |=> state == ST_AWAKE)
        else $error("start bit did not wake the device");

    a_wake_tx: assert property (
        (state == ST_ASLEEP) && |tx_load |=> state == ST_AWAKE && osc_en_o)
        else $error("transmit load did not wake the device");

    a_wake_modem: assert property (
        (state == ST_ASLEEP) && |modem_change |=> state == ST_AWAKE)
        else $error("modem change did not wake the device");

    a_wake_irq: assert property (
        (state == ST_ASLEEP) && |wake_set |-> ##2 irq_o)
        else $error("wake-up raised no interrupt");

    a_silent_set: assert property (
        wake_set != 8'h00 |=> (wake_flag & $past(wake_set)) == $past(wake_set))
        else $error("silent wake flag not set");

    a_silent_clear: assert property (
        wake_clr != 8'h00 && wake_set == 8'h00 |=> (wake_flag & $past(wake_clr)) == 8'h00)
        else $error("empty status read left wake flag set");

    a_resleep: assert property (
        (state == ST_AWAKE) && entry_ok |=> state == ST_ASLEEP)
        else $error("device did not return to sleep");

    a_sleep_off: assert property (
        sleep_enable != SLEEP_ALL |=> state == ST_AWAKE)
        else $error("asleep with sleep disabled");

    a_soft_pulse: assert property (
        soft_reset_o != 8'h00 |-> $past(host_wr_global && addr_i == OFS_SOFT_RESET))
        else $error("soft reset pulse without a write");

    a_broadcast_fan: assert property (
        host_wr_chan && broadcast_write_control[BCAST_BIT] |=> chan_bus_o.sel == 8'hFF)
        else $error("broadcast write not sent to all channels");

    c_sleep: cover property ($rose(state == ST_ASLEEP));
    c_rx_wake: cover property ((state == ST_ASLEEP) && |rx_fall);
    c_silent: cover property (wake_set != 8'h00 ##[1:20] wake_clr != 8'h00);
    c_resleep: cover property ($fell(state == ST_ASLEEP) ##[1:50] $rose(state == ST_ASLEEP));

endmodule : octal_uart_cfg

// [test/host_model.sv]
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic       sys_clk_i,
    // parallel bus towards the device
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    ////////////////////////////////////////////////////////////////////////
    // bus idles with no strobe at time zero
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one-cycle strobe; released lines show inverted leftovers so a stale
    // address or data byte can never pass for the real one
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge sys_clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= w;
        rd_o    <= !w;
        @(negedge sys_clk_i);
        addr_o  <= ~a;
        wdata_o <= ~d;
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
    endtask : access

    // modem status read, so the channel drops its change flags
    task automatic read_modem(input logic [2:0] ch);
        access({1'b0, ch, 4'h6}, 8'h00, 1'b0);
    endtask : read_modem

    // first characters after wake are not trusted; let the oscillator settle
    task automatic restart_wait();
        repeat (8) @(negedge sys_clk_i);
    endtask : restart_wait
endmodule : host_model

// [test/octal_uart_cfg_bench.sv]
`timescale 1ns/100ps
module octal_uart_cfg_bench;
    import octal_uart_cfg_pkg::*;
    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    localparam logic [7:0] IDV = 8'h3C; // arbitrary value
    logic        sys_clk_i, rst_b_i, wr_i, rd_i, irq_o, osc_en_o, oscillator_output_pin;
    logic [7:0]  addr_i, wdata_i, rdata_o, soft_reset_o, chan_irq_pending_i;
    logic [7:0]  rx_irq_en_i, tx_irq_en_i, modem_irq_en_i, modem_delta_i, rx_i;
    logic [63:0] chan_rdata_i;
    logic [23:0] chan_irq_code_i;
    logic [31:0] modem_i;
    logic [15:0] sample_mode_o, timer_reload_o;
    logic [3:0]  timer_ctrl_o;
    chan_bus_t   chan_bus_o;
    logic [7:0]  rd_q[$];
    chan_bus_t   bus_q[$];
    logic [7:0]  rst_q[$];
    logic        took_rd, bcast, p;
    logic [7:0]  d, x8, x4;
    logic [23:0] cx;
    int          err_count = 0;
    int          checked = 0;
    integer      seed = 84740;

    octal_uart_cfg #(.DEV_REVISION(REV), .DEV_IDENTIFIER(IDV), .CHANNELS(8))
        octal_uart_cfg_inst (.sys_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .chan_rdata_i, .chan_bus_o, .soft_reset_o, .sample_mode_o,
        .chan_irq_pending_i, .chan_irq_code_i, .rx_irq_en_i, .tx_irq_en_i,
        .modem_irq_en_i, .modem_delta_i, .rx_i, .modem_i, .irq_o, .osc_en_o,
        .oscillator_output_pin, .timer_ctrl_o, .timer_reload_o);
    host_model host_model_inst (.sys_clk_i(sys_clk_i), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // results are compared against the oldest note when they appear
    always @(posedge sys_clk_i) took_rd <= rd_i;
    always @(negedge sys_clk_i) begin
        if (took_rd === 1'b1) check(rdata_o, rd_q.pop_front());
        // read forwards carry no meaningful data byte, so it is masked off
        if (chan_bus_o.wr === 1'b1 || chan_bus_o.rd === 1'b1)
            check(chan_bus_o & (chan_bus_o.rd ? 22'h3FFC03 : 22'h3FFFFF),
                  bus_q.pop_front());
        if (soft_reset_o !== 8'h00) check(soft_reset_o, rst_q.pop_front());
    end

    // bus helpers note what the device must answer
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        if (!a[7]) bus_q.push_back({bcast ? 8'hFF : 8'h01 << a[6:4], a[3:0], v, 2'b10});
        if (a == OFS_SOFT_RESET && v != 8'h00) rst_q.push_back(v);
        if (a == OFS_BROADCAST) bcast = v[BCAST_BIT];
        host_model_inst.access(a, v, 1'b1);
    endtask : wr

    task automatic note_rd(input logic [7:0] a, input logic [7:0] exp);
        if (!a[7]) bus_q.push_back({8'h01 << a[6:4], a[3:0], 8'h00, 2'b01});
        rd_q.push_back(exp);
    endtask : note_rd

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        note_rd(a, exp);
        host_model_inst.access(a, 8'h00, 1'b0);
    endtask : rd

    // bounded wait for the oscillator enable to reach a level
    task automatic wait_osc(input logic v);
        int n;
        n = 0;
        while (osc_en_o !== v && n < 12) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(osc_en_o, v);
    endtask : wait_osc

    // silent wake: flag shows in the summary, status read clears it
    task automatic wake_check(input logic [2:0] ch);
        wait_osc(1'b1);
        host_model_inst.restart_wait();
        check(irq_o, 1'b1);
        rd(OFS_IRQ_SUMMARY, 8'h01 << ch);
        rd({1'b0, ch, CH_OFS_IRQ_STAT}, chan_rdata_i[8*ch+:8]);
        repeat (2) @(negedge sys_clk_i);
        check(irq_o, 1'b0);
    endtask : wake_check

    function automatic logic [7:0] reset_value(input logic [7:0] a);
        case (a)
            OFS_REVISION:   return REV;
            OFS_IDENTIFIER: return IDV;
            default:        return REG_RESET;
        endcase
    endfunction : reset_value

    ////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #600000;
        err_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        {rst_b_i, chan_rdata_i, chan_irq_pending_i, chan_irq_code_i} = '0;
        {rx_irq_en_i, tx_irq_en_i, modem_irq_en_i, modem_delta_i, modem_i} = '0;
        rx_i  = 8'hFF;
        bcast = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        // read-only and unmapped places ignore writes
        for (int a = 8'h80; a < 8'h90; a++)
            if (a < 8'h84 || a == 8'h85 || a == 8'h8C || a == 8'h8D || a == 8'h8F)
                wr(8'(a), 8'hFF);
        for (int a = 8'h80; a < 8'h90; a++) rd(8'(a), reset_value(8'(a)));
        $display("test 1 done");
        // timer slots, sampling modes, soft reset
        d = 8'($random(seed));
        wr(OFS_TIMER_CTRL, d);
        rd(OFS_TIMER_CTRL, d & TIMER_CTRL_MASK);
        wr(OFS_TIMER_LOW, d);
        wr(OFS_TIMER_HIGH, ~d);
        // the reload output follows the register one edge later
        @(negedge sys_clk_i);
        check({timer_ctrl_o, timer_reload_o}, {d[3:0], ~d, d});
        x8 = (8'($random(seed)) | 8'h81) & 8'hBF;
        x4 = (8'($random(seed)) | 8'h80) & 8'hBE;
        wr(OFS_SAMPLE_X8, x8);
        wr(OFS_SAMPLE_X4, x4);
        rd(OFS_SAMPLE_X8, x8);
        rd(OFS_SAMPLE_X4, x4);
        for (int n = 0; n < 8; n++)
            check(sample_mode_o[2*n+:2], x4[n] ? SAMPLE_4X : x8[n] ? SAMPLE_8X
                  : SAMPLE_16X);
        wr(OFS_SOFT_RESET, d | 8'h01);
        rd(OFS_SOFT_RESET, 8'h00);
        $display("test 2 done");
        // channel windows, then broadcast writes
        chan_rdata_i = {32'($random(seed)), 32'($random(seed))};
        for (int n = 0; n < 8; n++) begin
            rd({1'b0, 3'(n), 4'h7}, chan_rdata_i[8*n+:8]);
            wr({1'b0, 3'(n), 4'h5}, 8'(n) ^ d);
        end
        wr(OFS_BROADCAST, 8'hFF);
        rd(OFS_BROADCAST, 8'h01);
        wr(8'h12, 8'h55);
        wr(OFS_BROADCAST, 8'h00);
        $display("test 3 done");
        // interrupt summary and packed source codes
        chan_irq_pending_i = 8'($random(seed)) | 8'h10;
        chan_irq_code_i    = 24'($random(seed));
        cx = chan_irq_code_i;
        // a channel without a pending request reports no source
        for (int n = 0; n < 8; n++) if (!chan_irq_pending_i[n]) cx[3*n+:3] = 3'b000;
        rd(OFS_IRQ_SUMMARY, chan_irq_pending_i);
        rd(OFS_IRQ_CODE_LO, cx[7:0]);
        rd(OFS_IRQ_CODE_MID, cx[15:8]);
        rd(OFS_IRQ_CODE_HI, cx[23:16]);
        check(irq_o, 1'b1);
        $display("test 4 done");
        // sleep entry needs every enable bit, and stops the oscillator pin
        {chan_irq_pending_i, chan_irq_code_i} = '0;
        wr(OFS_SLEEP_EN, 8'h7F);
        repeat (6) @(negedge sys_clk_i);
        check(osc_en_o, 1'b1);
        wr(OFS_SLEEP_EN, SLEEP_ALL);
        wait_osc(1'b0);
        p = 1'b0;
        repeat (4) @(negedge sys_clk_i) p |= oscillator_output_pin;
        check(p, 1'b0);
        // start bit on channel 3
        rx_i[3] = 1'b0;
        @(negedge sys_clk_i);
        rx_i[3] = 1'b1;
        wake_check(3'd3);
        wait_osc(1'b0);
        // transmit load on channel 5
        wr(8'h50, d);
        wake_check(3'd5);
        wait_osc(1'b0);
        // modem line change on channel 1; change flag blocks sleep
        modem_i[4]       = 1'b1;
        modem_delta_i[1] = 1'b1;
        wake_check(3'd1);
        repeat (6) @(negedge sys_clk_i);
        check(osc_en_o, 1'b1);
        note_rd(8'h16, chan_rdata_i[15:8]);
        host_model_inst.read_modem(3'd1);
        modem_delta_i[1] = 1'b0;
        wait_osc(1'b0);
        // enabled start bit: the channel's own request stands, no silent flag
        rx_irq_en_i[6] = 1'b1;
        rx_i[6] = 1'b0;
        @(negedge sys_clk_i);
        {rx_i[6], chan_irq_pending_i[6]} = 2'b11;
        wait_osc(1'b1);
        rd(OFS_IRQ_SUMMARY, 8'h40);
        chan_irq_pending_i[6] = 1'b0;
        wait_osc(1'b0);
        // zero sleep enable ends sleep for good
        wr(OFS_SLEEP_EN, 8'h00);
        wait_osc(1'b1);
        repeat (8) @(negedge sys_clk_i);
        check(osc_en_o, 1'b1);
        // awake again, so the oscillator pin swings every clock
        p = oscillator_output_pin;
        @(negedge sys_clk_i);
        check(oscillator_output_pin, !p);
        check(rd_q.size() + bus_q.size() + rst_q.size(), 0);
        $display("test 5 done");
        give_verdict();
    end
endmodule : octal_uart_cfg_bench
